// *** design/pmc_cfg.svh ***
/*
 * Offsets, field positions and reset values of the PHY control
 * register. Assumes inclusion from the design module.
 */
//
// Behaviour
// - control register decoded at absolute address zero
// - reset defaults give normal operation without setup
// - sixteen-bit register resets to 0x3100
// - isolate bit 10 disconnects transmit and receive
// - bit 9 restarts negotiation, then self-clears
// - bit 7 selects collision test mode
// - bit 7 set on transmit start, cleared at halt
// - advertisement change waits for negotiation restart
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_ADDR_CONTROL 5'h00
`define PMC_ADDR_ADVERT 5'h04
`define PMC_RESET_VALUE 16'h3100
`define PMC_ADVERT_RESET 16'h01e1
`define PMC_BIT_SWRESET 15
`define PMC_BIT_LOOPBACK 14
`define PMC_BIT_RATE 13
`define PMC_BIT_ANEG_EN 12
`define PMC_BIT_LOWPWR 11
`define PMC_BIT_ISOLATE 10
`define PMC_BIT_RESTART 9
`define PMC_BIT_DUPLEX 8
`define PMC_BIT_COLCHK 7

`endif

// *** design/pmc_pkg.sv ***
/*
 * Types shared by the PHY control register block.
 * Assumes pmc_cfg.svh is on the include path.
 */
package pmc_pkg;

    // management register access from the MAC side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pmc_req_s;

    // decoded mode controls handed to the PHY core
    typedef struct packed {
        logic sw_reset;
        logic loop_back_mode;
        logic rate_select;
        logic autoneg_enable;
        logic low_power_mode;
        logic isolate;
        logic autoneg_restart;
        logic full_duplex;
        logic collision_check_mode;
    } pmc_ctl_s;

    typedef struct packed {
        logic [15:0] phy_control;
        logic [15:0] autoneg_advert;
        logic [15:0] advert_live;
        logic [15:0] rdata;
        logic tx_active;
    } pmc_state_s;

endpackage

// *** design/pmc_control.sv ***
/*
 * PHY management control register at address zero plus the held
 * advertisement register, with isolate and loop-back data steering.
 * Assumes the MAC management port is synchronous to clk_in and that
 * transmit start and halt are one-cycle pulses from the PHY core.
 */
`timescale 1ns/1ps
`include "pmc_cfg.svh"

module pmc_control
    import pmc_pkg::*;
(
    input wire logic clk_in, // 100 MHz system clock
    input wire logic nrst_in, // synchronous reset, active low
    input wire pmc_req_s req_in, // management read or write
    output logic [15:0] rdata_out, // read data, one cycle after rd
    output pmc_ctl_s ctl_out, // decoded control bits
    output logic [15:0] advert_out, // advertisement used by negotiation
    input wire logic tx_start_in, // transmission initiated pulse
    input wire logic tx_halt_in, // transmission halted pulse
    input wire logic [3:0] mac_txd_in, // transmit nibble from MAC
    input wire logic mac_txen_in, // transmit enable from MAC
    input wire logic [3:0] line_rxd_in, // receive nibble from line
    input wire logic line_rxdv_in, // receive valid from line
    output logic [3:0] line_txd_out, // transmit nibble to line
    output logic line_txen_out, // transmit enable to line
    output logic [3:0] mac_rxd_out, // receive nibble to MAC
    output logic mac_rxdv_out // receive valid to MAC
);

    pmc_state_s st_r;
    pmc_state_s st_nxt;
    logic wr_ctl;
    logic wr_adv;
    logic [15:0] ctl_v;

    ////////////////////////////////////////////////////////////////////
    assign wr_ctl = req_in.wr && req_in.addr == `PMC_ADDR_CONTROL;
    assign wr_adv = req_in.wr && req_in.addr == `PMC_ADDR_ADVERT;

    always_comb begin
        st_nxt = st_r;
        ctl_v = st_r.phy_control;
        // restart is one cycle wide: it has started once seen
        ctl_v[`PMC_BIT_RESTART] = 1'b0;
        if (wr_ctl) begin
            ctl_v = req_in.wdata;
        end
        if (tx_start_in && !tx_halt_in) begin
            st_nxt.tx_active = 1'b1;
        end else if (tx_halt_in) begin
            st_nxt.tx_active = 1'b0;
        end
        // hardware tracking wins over a same-cycle software write
        if (tx_start_in && !tx_halt_in) begin
            ctl_v[`PMC_BIT_COLCHK] = 1'b1;
        end else if (tx_halt_in) begin
            ctl_v[`PMC_BIT_COLCHK] = 1'b0;
        end
        st_nxt.phy_control = ctl_v;
        if (wr_adv) begin
            st_nxt.autoneg_advert = req_in.wdata;
        end
        // held advert only goes live on restart
        if (st_r.phy_control[`PMC_BIT_RESTART]) begin
            st_nxt.advert_live = st_r.autoneg_advert;
        end
        unique case (req_in.addr)
            `PMC_ADDR_CONTROL: st_nxt.rdata = st_r.phy_control;
            `PMC_ADDR_ADVERT: st_nxt.rdata = st_r.autoneg_advert;
            default: st_nxt.rdata = 16'h0000;
        endcase
        if (!req_in.rd) begin
            st_nxt.rdata = st_r.rdata;
        end
        // software reset: whole state back to defaults, bit self-clears
        if (st_r.phy_control[`PMC_BIT_SWRESET]) begin
            st_nxt.phy_control = `PMC_RESET_VALUE;
            st_nxt.autoneg_advert = `PMC_ADVERT_RESET;
            st_nxt.advert_live = `PMC_ADVERT_RESET;
            st_nxt.rdata = 16'h0000;
            st_nxt.tx_active = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            st_r.phy_control <= `PMC_RESET_VALUE;
            st_r.autoneg_advert <= `PMC_ADVERT_RESET;
            st_r.advert_live <= `PMC_ADVERT_RESET;
            st_r.rdata <= 16'h0000;
            st_r.tx_active <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign rdata_out = st_r.rdata;
    assign advert_out = st_r.advert_live;
    assign ctl_out.sw_reset = st_r.phy_control[`PMC_BIT_SWRESET];
    assign ctl_out.loop_back_mode = st_r.phy_control[`PMC_BIT_LOOPBACK];
    assign ctl_out.rate_select = st_r.phy_control[`PMC_BIT_RATE];
    assign ctl_out.autoneg_enable = st_r.phy_control[`PMC_BIT_ANEG_EN];
    assign ctl_out.low_power_mode = st_r.phy_control[`PMC_BIT_LOWPWR];
    assign ctl_out.isolate = st_r.phy_control[`PMC_BIT_ISOLATE];
    assign ctl_out.autoneg_restart = st_r.phy_control[`PMC_BIT_RESTART];
    assign ctl_out.full_duplex = st_r.phy_control[`PMC_BIT_DUPLEX];
    assign ctl_out.collision_check_mode =
        st_r.phy_control[`PMC_BIT_COLCHK];

    // isolate beats loop-back: both paths silent
    always_comb begin
        line_txd_out = 4'h0;
        line_txen_out = 1'b0;
        mac_rxd_out = 4'h0;
        mac_rxdv_out = 1'b0;
        if (!ctl_out.isolate) begin
            if (ctl_out.loop_back_mode) begin
                mac_rxd_out = mac_txd_in;
                mac_rxdv_out = mac_txen_in;
            end else begin
                line_txd_out = mac_txd_in;
                line_txen_out = mac_txen_in;
                mac_rxd_out = line_rxd_in;
                mac_rxdv_out = line_rxdv_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    chk_reset_value: assert property (@(posedge clk_in)
        !nrst_in |=> st_r.phy_control == `PMC_RESET_VALUE)
        else $error("control not at reset value");

    chk_restart_clears: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.autoneg_restart && !wr_ctl |=> !ctl_out.autoneg_restart)
        else $error("restart bit did not clear");

    chk_swreset_clears: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.sw_reset |=> st_r.phy_control == `PMC_RESET_VALUE)
        else $error("software reset did not restore defaults");

    chk_isolate_paths: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.isolate |-> !line_txen_out && !mac_rxdv_out)
        else $error("isolate left a data path open");

    chk_loop_back: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.loop_back_mode && !ctl_out.isolate
            |-> mac_rxdv_out == mac_txen_in && !line_txen_out)
        else $error("loop-back path wrong");

    chk_colchk_set: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        tx_start_in && !tx_halt_in && !ctl_out.sw_reset
            |=> ctl_out.collision_check_mode)
        else $error("collision check not set on transmit");

    chk_colchk_clear: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        tx_halt_in |=> !ctl_out.collision_check_mode)
        else $error("collision check not cleared on halt");

    chk_advert_held: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        !ctl_out.autoneg_restart && !ctl_out.sw_reset
            |=> $stable(advert_out))
        else $error("advert changed without restart");

    chk_ctl_decode: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        wr_ctl && !ctl_out.sw_reset && !tx_start_in && !tx_halt_in
            |=> st_r.phy_control == $past(req_in.wdata))
        else $error("write at address zero not stored");

    chk_advert_write: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        wr_adv && !ctl_out.sw_reset
            |=> st_r.autoneg_advert == $past(req_in.wdata))
        else $error("advertisement write not held");

    chk_advert_live: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.autoneg_restart && !ctl_out.sw_reset
            |=> advert_out == $past(st_r.autoneg_advert))
        else $error("held advertisement not applied on restart");

    chk_read_control: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        req_in.rd && req_in.addr == `PMC_ADDR_CONTROL && !ctl_out.sw_reset
            |=> rdata_out == $past(st_r.phy_control))
        else $error("read at address zero wrong");

    chk_read_unmapped: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        req_in.rd && req_in.addr != `PMC_ADDR_CONTROL
            && req_in.addr != `PMC_ADDR_ADVERT && !ctl_out.sw_reset
            |=> rdata_out == 16'h0000)
        else $error("read of undefined address not zero");

    chk_read_held: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        !req_in.rd && !ctl_out.sw_reset |=> $stable(rdata_out))
        else $error("read data moved without a read");

    chk_normal_paths: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        !ctl_out.isolate && !ctl_out.loop_back_mode
            |-> line_txd_out == mac_txd_in && line_txen_out == mac_txen_in
            && mac_rxd_out == line_rxd_in && mac_rxdv_out == line_rxdv_in)
        else $error("normal data path not passed through");

    chk_isolate_data: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.isolate |-> line_txd_out == 4'h0 && mac_rxd_out == 4'h0)
        else $error("isolate left data on a path");

    chk_loop_data: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        ctl_out.loop_back_mode && !ctl_out.isolate
            |-> mac_rxd_out == mac_txd_in && line_txd_out == 4'h0)
        else $error("loop-back data path wrong");

endmodule

// *** test/pmc_mac_model.sv ***
/*
 * Management master model: software issuing control register
 * accesses. Assumes callers enter its tasks just after a clock edge.
 */
`timescale 1ns/1ps

module pmc_mac_model
    import pmc_pkg::*;
(
    input wire logic clk_in, // system clock
    input wire logic [15:0] rdata_in, // read data from block
    output pmc_req_s req_out // request to block
);
    initial req_out = '0;

    // only defined addresses, control low field written as zero
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = (a == 5'h00) ? {d[15:7], 7'h00} : d;
        // idle edge first, so a strobe never drops and rises at once
        @(posedge clk_in);
        #1;
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_in);
        #1;
        // released data bus shows junk, not the last word
        req_out = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~v};
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_in);
        #1;
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_in);
        #1;
        // registered on the request edge, stands until the next read or a software reset
        d = rdata_in;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 16'h0000};
    endtask
endmodule

// *** test/pmc_control_bench.sv ***
/*
 * Self-checking bench of the control register block.
 * Assumes design/ on the include path; inputs move 1 ns after edges.
 */
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    fail_count++; $display("unexpected %s exp %h got %h", n, e, a); end end

module pmc_control_bench
    import pmc_pkg::*;
;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic tx_start_in = 1'b0;
    logic tx_halt_in = 1'b0;
    logic [3:0] mac_txd_in = 4'ha;
    logic [3:0] line_rxd_in = 4'h5;
    logic mac_txen_in = 1'b1;
    logic line_rxdv_in = 1'b1;
    logic [15:0] rdata_out, advert_out, d;
    logic [3:0] line_txd_out, mac_rxd_out;
    logic line_txen_out, mac_rxdv_out;
    pmc_req_s req;
    pmc_ctl_s ctl_out;
    int fail_count = 0;
    int n_compared = 0;

    always #5 clk_in = ~clk_in;

    pmc_mac_model mac (.clk_in(clk_in), .rdata_in(rdata_out), .req_out(req));
    pmc_control DUT (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req),
        .rdata_out(rdata_out), .ctl_out(ctl_out), .advert_out(advert_out),
        .tx_start_in(tx_start_in), .tx_halt_in(tx_halt_in),
        .mac_txd_in(mac_txd_in), .mac_txen_in(mac_txen_in),
        .line_rxd_in(line_rxd_in), .line_rxdv_in(line_rxdv_in),
        .line_txd_out(line_txd_out),
        .line_txen_out(line_txen_out), .mac_rxd_out(mac_rxd_out),
        .mac_rxdv_out(mac_rxdv_out));

    task step;
        @(posedge clk_in);
        #1;
    endtask

    task finish_test;
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task t_defaults;
        mac.rd(5'h00, d);
        `CHK("control", 16'h3100, d)
        `CHK("advert", 16'h01e1, advert_out)
        `CHK("line_txd", 4'ha, line_txd_out)
        `CHK("mac_rxd", 4'h5, mac_rxd_out)
        `CHK("mac_rxdv", 1'b1, mac_rxdv_out)
        `CHK("ctl", 9'h062, ctl_out)
        mac.rd(5'h01, d);
        `CHK("unmapped", 16'h0000, d)
    endtask

    task t_restart;
        mac.wr(5'h04, 16'h0061);
        `CHK("advert held", 16'h01e1, advert_out)
        mac.wr(5'h00, 16'h3300);
        `CHK("restart", 1'b1, ctl_out.autoneg_restart)
        step();
        `CHK("restart clr", 1'b0, ctl_out.autoneg_restart)
        `CHK("advert live", 16'h0061, advert_out)
    endtask

    task t_collision;
        tx_start_in = 1'b1;
        step();
        tx_start_in = 1'b0;
        `CHK("col set", 1'b1, ctl_out.collision_check_mode)
        tx_halt_in = 1'b1;
        step();
        tx_halt_in = 1'b0;
        `CHK("col clr", 1'b0, ctl_out.collision_check_mode)
        mac.wr(5'h00, 16'h3180);
        `CHK("col mode", 1'b1, ctl_out.collision_check_mode)
    endtask

    task t_paths;
        mac.wr(5'h00, 16'h3d00);
        `CHK("iso ctl", 9'h07a, ctl_out)
        `CHK("iso txd", 4'h0, line_txd_out)
        `CHK("iso rxdv", 1'b0, mac_rxdv_out)
        line_rxdv_in = 1'b0;
        mac.wr(5'h00, 16'h7100);
        `CHK("lb rxd", 4'ha, mac_rxd_out)
        `CHK("lb rxdv", 1'b1, mac_rxdv_out)
        `CHK("lb txen", 1'b0, line_txen_out)
        mac_txen_in = 1'b0;
        step();
        `CHK("lb rxdv off", 1'b0, mac_rxdv_out)
        mac_txen_in = 1'b1;
        line_rxdv_in = 1'b1;
    endtask

    task t_swreset;
        mac.wr(5'h00, 16'hb100);
        `CHK("swrst", 1'b1, ctl_out.sw_reset)
        step();
        mac.rd(5'h00, d);
        `CHK("after swrst", 16'h3100, d)
        `CHK("advert swrst", 16'h01e1, advert_out)
    endtask

    initial begin
        #100000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        t_defaults();
        t_restart();
        t_collision();
        t_paths();
        t_swreset();
        finish_test();
    end
endmodule
